// ---- rtl/stack_mem_end.sv ----
// memory-package end: die selection, write capture, protect and wait drive
`timescale 1ns/1ps
// Function
// RL1: wait asserted until read data valid
// RL2: wait driven when die selected, oe low
// RL3: wait high-z when deselected or oe high
// RL4: flash writes only while strobe low, enabled
// RL5: flash latches address and data on rising strobe
// RL6: ram latches write data on rising strobe
// RL7: protect low enforces lock-down
// RL8: protect high lets unlock clear lock-down
// RL9: one protect die1, one for other dies
// RL10: control strobe high reaches pram registers
// RL11: async mode strobe low reaches config
// RL12: pram die selected by own select
// RL13: two pram selects, one per die
// RL14: sram needs both selects active
// RL15: byte enables gate upper and lower lanes
// RL16: control and mode strobes share one contact
// RL17: flash enable low selects, high standby
// RL18: flash oe low drives outputs
// RL19: host sends address then data
// RL20: address strobe high in data phase
// RL21: host selects one die at a time
module stack_mem_end
#(
    parameter logic pram_async_only = 1'b0,
    parameter logic wait_active_high = 1'b1,
    parameter logic [2:0] read_latency = 3'h2
)
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    stack_bus_if.mem         bus,
    output logic [22:0]      last_addr,
    output logic [15:0]      last_data,
    output logic [2:0]       last_die,
    output logic             write_seen,
    output logic             block_locked,
    output logic             pram_cfg_access,
    output logic [15:0]      pram_refresh_ctrl_reg,
    output logic [15:0]      pram_bus_ctrl_reg
);
    // ===========================================================
    // pin synchronisers
    localparam int NP = 15;
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] lv;
    logic [NP-1:0] rs;
    logic [15:0]   dq_s1;
    logic [15:0]   dq_s;
    logic [6:0]    hi_s1;
    logic [6:0]    hi_s;

    assign pin_raw = {bus.flash_write_protect_others_n,
                      bus.link_clk, bus.address_valid_strobe_n, bus.flash_ce_n,
                      bus.flash_oe_n, bus.flash_we_n, bus.flash_rst_n,
                      bus.flash_write_protect_die1_n, bus.pram_die1_select_n,
                      bus.pram_die2_select_n, bus.sram_select_low_n, bus.sram_select_high,
                      bus.ram_oe_n, bus.ram_we_n, bus.pram_ctrl_reg_strobe};

    pin_sync #(.W(NP)) u_sync
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .pin     (pin_raw),
        .level   (lv),
        .rise    (rs),
        .fall    ()
    );

    always_ff @(posedge ref_clk)
    begin
        dq_s1 <= bus.dq_host;
        dq_s  <= dq_s1;
        hi_s1 <= bus.addr_hi;
        hi_s  <= hi_s1;
    end

    logic adv_n;
    logic f_ce_n;
    logic f_oe_n;
    logic f_rst_n;
    logic wp1_n;
    logic p1_n;
    logic p2_n;
    logic s_lo_n;
    logic s_hi;
    logic r_oe_n;
    logic cre;
    logic f_we_rise;
    logic r_we_rise;
    logic clk_rise;
    logic wp2_n;

    assign wp2_n     = lv[14];
    assign adv_n     = lv[12];
    assign clk_rise  = rs[13];
    assign f_ce_n    = lv[11];
    assign f_oe_n    = lv[10];
    assign f_we_rise = rs[9];
    assign f_rst_n   = lv[8];
    assign wp1_n     = lv[7];
    assign p1_n      = lv[6];
    assign p2_n      = lv[5];
    assign s_lo_n    = lv[4];
    assign s_hi      = lv[3];
    assign r_oe_n    = lv[2];
    assign r_we_rise = rs[1];
    assign cre       = lv[0];

    // ===========================================================
    // die selection
    logic flash_sel;
    logic pram_sel;
    logic sram_sel;
    logic [2:0] sel_die;
    assign flash_sel = ~f_ce_n; // RL17
    assign pram_sel  = ~p1_n | ~p2_n; // RL12 RL13
    assign sram_sel  = ~s_lo_n & s_hi; // RL14
    always_comb
    begin
        if (flash_sel)
            sel_die = 3'(stack_pkg::DIE_FLASH);
        else if (!p1_n)
            sel_die = 3'(stack_pkg::DIE_PRAM1); // RL13
        else if (!p2_n)
            sel_die = 3'(stack_pkg::DIE_PRAM2); // RL13
        else if (sram_sel)
            sel_die = 3'(stack_pkg::DIE_SRAM);
        else
            sel_die = 3'(stack_pkg::DIE_NONE);
    end

    // ===========================================================
    // address flows while strobe low, held from its rise; data shares the lines
    logic [22:0] addr_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            addr_q <= '0;
        else if (!adv_n)
            addr_q <= {hi_s, dq_s};
    end

    // sample of the multiplexed data lines, taken when address strobe is high
    logic [15:0] data_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            data_q <= stack_pkg::MEM_RST;
        else if (adv_n)
            data_q <= dq_s;
    end

    // ===========================================================
    // write capture on strobe rising edges
    logic flash_wr;
    logic ram_wr;
    logic mode_cfg;
    logic [1:0] lanes;
    // one contact, two meanings, fixed by the stacked combination
    assign mode_cfg = pram_async_only ? ~cre : cre; // RL16 RL10 RL11
    assign flash_wr = f_we_rise & flash_sel & f_rst_n; // RL4 RL5
    assign ram_wr   = r_we_rise & (pram_sel | sram_sel); // RL6
    // byte lanes change slower than the strobe; two plain register stages are enough
    always_ff @(posedge ref_clk)
    begin
        lanes <= ~{bus.ram_upper_byte_en_n, bus.ram_lower_byte_en_n};
    end
    logic [1:0] lanes_s;
    always_ff @(posedge ref_clk)
    begin
        lanes_s <= lanes;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            last_addr <= '0;
            last_data <= stack_pkg::MEM_RST;
            last_die  <= 3'(stack_pkg::DIE_NONE);
        end
        else if (flash_wr)
        begin
            last_addr <= addr_q; // RL5
            last_data <= data_q; // RL5
            last_die  <= sel_die;
        end
        else if (ram_wr)
        begin
            last_addr <= addr_q;
            last_data <= {lanes_s[1] ? data_q[15:8] : last_data[15:8],
                          lanes_s[0] ? data_q[7:0] : last_data[7:0]}; // RL15
            last_die  <= sel_die;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            write_seen <= 1'b0;
        else
            write_seen <= flash_wr | ram_wr;
    end

    // ===========================================================
    // pram control register access
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pram_refresh_ctrl_reg <= stack_pkg::MEM_RST;
            pram_bus_ctrl_reg     <= stack_pkg::MEM_RST;
            pram_cfg_access       <= 1'b0;
        end
        else
        begin
            pram_cfg_access <= mode_cfg & pram_sel; // RL10 RL11
            if (ram_wr && pram_sel && mode_cfg)
            begin
                if (addr_q[0])
                    pram_bus_ctrl_reg <= data_q; // RL10
                else
                    pram_refresh_ctrl_reg <= data_q; // RL10
            end
        end
    end

    // ===========================================================
    // lock-down: data 16'h0001 locks, 16'h0000 unlocks one shared flag, gated by the addressed die's protect pin
    logic wp_n;
    assign wp_n = (addr_q[22:21] == 2'h0) ? wp1_n : wp2_n; // RL9
    always_ff @(posedge ref_clk)
    begin
        if (reset || !f_rst_n)
            block_locked <= 1'b0;
        else if (flash_wr && data_q == 16'h0001)
            block_locked <= 1'b1; // RL7
        else if (flash_wr && data_q == 16'h0000 && wp_n)
            block_locked <= 1'b0; // RL8
    end

    // ===========================================================
    // read path and wait indicator
    logic wait_en;
    logic [2:0] lat_cnt;
    logic drive_data;
    assign wait_en = (flash_sel & ~f_oe_n) | (pram_sel & ~pram_async_only & ~r_oe_n); // RL2
    assign drive_data = (flash_sel & ~f_oe_n) | ((pram_sel | sram_sel) & ~r_oe_n); // RL18

    always_ff @(posedge ref_clk)
    begin
        if (reset || !wait_en || !adv_n)
            lat_cnt <= read_latency;
        else if (clk_rise && lat_cnt != 3'h0)
            lat_cnt <= lat_cnt - 3'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            bus.wait_out    <= ~wait_active_high;
            bus.wait_oe_n   <= 1'b1;
            bus.dq_mem      <= stack_pkg::MEM_RST;
            bus.dq_mem_oe_n <= 1'b1;
        end
        else
        begin
            bus.wait_oe_n   <= ~wait_en; // RL2 RL3
            bus.wait_out    <= (lat_cnt != 3'h0) ? wait_active_high : ~wait_active_high; // RL1
            bus.dq_mem_oe_n <= ~(drive_data & adv_n); // RL12 RL17
            bus.dq_mem      <= last_data;
        end
    end
endmodule

// ---- inc/stack_pkg.sv ----
// constants and types shared by both ends of the stacked memory bus
package stack_pkg;
    // ===========================================================
    // bus widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 23;
    localparam int HI_W   = 7;
    // ===========================================================
    // link clock divider: half period in ref_clk cycles
    localparam logic [3:0] CLK_HALF = 4'h4;
    // ===========================================================
    // reset values
    localparam logic [15:0] MEM_RST  = 16'h0000;
    localparam logic [6:0]  HI_RST   = 7'h00;
    localparam logic [1:0]  LANE_ALL = 2'h3;
    // die codes
    typedef enum logic [2:0]
    {
        DIE_FLASH = 3'h0,
        DIE_PRAM1 = 3'h1,
        DIE_PRAM2 = 3'h2,
        DIE_SRAM  = 3'h3,
        DIE_NONE  = 3'h7
    } die_t;
    // host sequencer states
    typedef enum logic [4:0]
    {
        H_IDLE = 5'b00001,
        H_ADDR = 5'b00010,
        H_DATA = 5'b00100,
        H_STRB = 5'b01000,
        H_DONE = 5'b10000
    } host_state_t;
endpackage

// ---- inc/stack_bus_if.sv ----
// pin-level bus between the host controller and the stacked memory
`timescale 1ns/1ps
interface stack_bus_if;
    logic [15:0] dq_host;
    logic        dq_host_oe_n;
    logic [15:0] dq_mem;
    logic        dq_mem_oe_n;
    logic [6:0]  addr_hi;
    logic        link_clk;
    logic        address_valid_strobe_n;
    logic        flash_ce_n;
    logic        flash_oe_n;
    logic        flash_we_n;
    logic        flash_rst_n;
    logic        flash_write_protect_die1_n;
    logic        flash_write_protect_others_n;
    logic        pram_die1_select_n;
    logic        pram_die2_select_n;
    logic        sram_select_low_n;
    logic        sram_select_high;
    logic        ram_oe_n;
    logic        ram_we_n;
    logic        ram_upper_byte_en_n;
    logic        ram_lower_byte_en_n;
    logic        pram_ctrl_reg_strobe;
    logic        wait_out;
    logic        wait_oe_n;
    modport host
    (
        output dq_host, dq_host_oe_n, addr_hi, link_clk, address_valid_strobe_n,
        output flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n,
        output flash_write_protect_die1_n, flash_write_protect_others_n,
        output pram_die1_select_n, pram_die2_select_n, sram_select_low_n,
        output sram_select_high, ram_oe_n, ram_we_n, ram_upper_byte_en_n,
        output ram_lower_byte_en_n, pram_ctrl_reg_strobe,
        input  dq_mem, dq_mem_oe_n, wait_out, wait_oe_n
    );
    modport mem
    (
        input  dq_host, dq_host_oe_n, addr_hi, link_clk, address_valid_strobe_n,
        input  flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n,
        input  flash_write_protect_die1_n, flash_write_protect_others_n,
        input  pram_die1_select_n, pram_die2_select_n, sram_select_low_n,
        input  sram_select_high, ram_oe_n, ram_we_n, ram_upper_byte_en_n,
        input  ram_lower_byte_en_n, pram_ctrl_reg_strobe,
        output dq_mem, dq_mem_oe_n, wait_out, wait_oe_n
    );
endinterface

// ---- rtl/pin_sync.sv ----
// two-flop synchroniser with rising and falling edge detect on the second stage
`timescale 1ns/1ps
module pin_sync
#(
    parameter int W = 1
)
(
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] stage1;
    logic [W-1:0] last;

    always_ff @(posedge ref_clk)
    begin
        stage1 <= pin;
        level  <= stage1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            last <= '1;
        end
        else
        begin
            last <= level;
        end
    end

    assign rise = level & ~last;
    assign fall = ~level & last;
endmodule

// ---- rtl/stack_host_end.sv ----
// host controller end: multiplexed write and read sequencing with divided link clock
`timescale 1ns/1ps
module stack_host_end
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    stack_bus_if.host        bus,
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [2:0]  req_die,
    input  wire logic [22:0] req_addr,
    input  wire logic [15:0] req_data,
    input  wire logic [1:0]  req_lanes,
    input  wire logic        req_cfg,
    input  wire logic        wp_die1,
    input  wire logic        wp_others,
    output logic             busy,
    output logic             done,
    output logic [15:0]      rd_data
);
    stack_pkg::host_state_t state;
    logic [3:0] div;
    logic [2:0] cnt;
    logic [2:0] die;
    logic       wr;
    logic [15:0] wdata;

    // free-running link clock divider
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            div          <= '0;
            bus.link_clk <= 1'b0;
        end
        else if (div == stack_pkg::CLK_HALF - 4'h1)
        begin
            div          <= '0;
            bus.link_clk <= ~bus.link_clk;
        end
        else
            div <= div + 4'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state <= stack_pkg::H_IDLE;
            cnt   <= '0;
            die   <= 3'(stack_pkg::DIE_NONE);
            wr    <= 1'b0;
            wdata <= '0;
        end
        else
        begin
            unique case (state)
                stack_pkg::H_IDLE:
                    if (req)
                    begin
                        state <= stack_pkg::H_ADDR;
                        die   <= req_die; // RL21
                        wr    <= req_write;
                        wdata <= req_data;
                        cnt   <= '0;
                    end
                stack_pkg::H_ADDR:
                begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'h5)
                    begin
                        state <= stack_pkg::H_DATA;
                        cnt   <= '0;
                    end
                end
                stack_pkg::H_DATA:
                begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'h5)
                    begin
                        state <= stack_pkg::H_STRB;
                        cnt   <= '0;
                    end
                end
                stack_pkg::H_STRB:
                begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'h7)
                        state <= stack_pkg::H_DONE;
                end
                stack_pkg::H_DONE:
                    state <= stack_pkg::H_IDLE;
            endcase
        end
    end

    logic strobe;
    logic sel_on;
    assign strobe = (state == stack_pkg::H_DATA) | (state == stack_pkg::H_STRB && cnt < 3'h4);
    assign sel_on = (state != stack_pkg::H_IDLE) && (state != stack_pkg::H_DONE);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            bus.dq_host                      <= stack_pkg::MEM_RST;
            bus.dq_host_oe_n                 <= 1'b1;
            bus.addr_hi                      <= stack_pkg::HI_RST;
            bus.address_valid_strobe_n       <= 1'b1;
            bus.flash_ce_n                   <= 1'b1;
            bus.flash_oe_n                   <= 1'b1;
            bus.flash_we_n                   <= 1'b1;
            bus.flash_rst_n                  <= 1'b0;
            bus.flash_write_protect_die1_n   <= 1'b0;
            bus.flash_write_protect_others_n <= 1'b0;
            bus.pram_die1_select_n           <= 1'b1;
            bus.pram_die2_select_n           <= 1'b1;
            bus.sram_select_low_n            <= 1'b1;
            bus.sram_select_high             <= 1'b0;
            bus.ram_oe_n                     <= 1'b1;
            bus.ram_we_n                     <= 1'b1;
            bus.ram_upper_byte_en_n          <= 1'b1;
            bus.ram_lower_byte_en_n          <= 1'b1;
            bus.pram_ctrl_reg_strobe         <= 1'b0;
            busy                             <= 1'b0;
            done                             <= 1'b0;
            rd_data                          <= '0;
        end
        else
        begin
            bus.flash_rst_n                  <= 1'b1;
            bus.flash_write_protect_die1_n   <= wp_die1; // RL9
            bus.flash_write_protect_others_n <= wp_others; // RL9
            bus.addr_hi                      <= req_addr[22:16];
            // address first, then data on the same lines
            bus.address_valid_strobe_n <= ~(state == stack_pkg::H_ADDR); // RL19 RL20
            bus.dq_host      <= (state == stack_pkg::H_ADDR) ? req_addr[15:0] : wdata; // RL19
            bus.dq_host_oe_n <= ~((state == stack_pkg::H_ADDR) | (wr & sel_on));
            bus.flash_ce_n   <= ~(sel_on && die == 3'(stack_pkg::DIE_FLASH)); // RL21
            bus.pram_die1_select_n <= ~(sel_on && die == 3'(stack_pkg::DIE_PRAM1));
            bus.pram_die2_select_n <= ~(sel_on && die == 3'(stack_pkg::DIE_PRAM2));
            bus.sram_select_low_n  <= ~(sel_on && die == 3'(stack_pkg::DIE_SRAM));
            bus.sram_select_high   <= sel_on && die == 3'(stack_pkg::DIE_SRAM);
            bus.flash_we_n <= ~(wr && strobe && die == 3'(stack_pkg::DIE_FLASH)); // RL4
            bus.ram_we_n   <= ~(wr && strobe && die != 3'(stack_pkg::DIE_FLASH)); // RL6
            bus.flash_oe_n <= ~(!wr && strobe && die == 3'(stack_pkg::DIE_FLASH));
            bus.ram_oe_n   <= ~(!wr && strobe && die != 3'(stack_pkg::DIE_FLASH));
            bus.ram_upper_byte_en_n  <= ~(sel_on & req_lanes[1]); // RL15
            bus.ram_lower_byte_en_n  <= ~(sel_on & req_lanes[0]); // RL15
            bus.pram_ctrl_reg_strobe <= sel_on & req_cfg; // RL10
            busy <= sel_on;
            done <= (state == stack_pkg::H_STRB && cnt == 3'h7);
            if (!wr && state == stack_pkg::H_STRB && cnt == 3'h3)
                rd_data <= bus.dq_mem;
        end
    end
endmodule

// ---- tb/stack_assertions.sv ----
// pin-level checks on the link between the host end and the memory end
`timescale 1ns/1ps
module stack_assertions
#(
    parameter logic wait_active_high = 1'b1
)
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [15:0] dq_host,
    input  wire logic        dq_host_oe_n,
    input  wire logic        dq_mem_oe_n,
    input  wire logic        address_valid_strobe_n,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic        ram_we_n,
    input  wire logic        pram_die1_select_n,
    input  wire logic        pram_die2_select_n,
    input  wire logic        sram_select_low_n,
    input  wire logic        sram_select_high,
    input  wire logic        wait_out,
    input  wire logic        wait_oe_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // ==========================================================
    // helpers
    logic none_sel;
    assign none_sel = flash_ce_n & pram_die1_select_n & pram_die2_select_n
                      & (sram_select_low_n | ~sram_select_high);
    sequence s_flash_low;
        !flash_we_n ##1 !flash_we_n;
    endsequence
    sequence s_ram_low;
        !ram_we_n ##1 !ram_we_n;
    endsequence
    // ==========================================================
    // checks; five cycles of settling cover the pin synchronisers
    AST_WAIT_HIZ: assert property ((flash_ce_n && pram_die1_select_n && pram_die2_select_n)[*5]
        |-> wait_oe_n) else $error("wait driven while deselected");
    AST_WAIT_DRIVE: assert property ((!flash_ce_n && !flash_oe_n)[*5] |-> !wait_oe_n)
        else $error("wait not driven during flash read");
    AST_WAIT_START: assert property ($fell(wait_oe_n) |-> wait_out == wait_active_high)
        else $error("wait not asserted at start of read");
    AST_WAIT_END: assert property ($fell(wait_oe_n) |-> ##[1:40]
        (wait_out != wait_active_high || wait_oe_n)) else $error("wait never released");
    AST_DQ_HIZ: assert property (none_sel[*5] |-> dq_mem_oe_n)
        else $error("data driven with no die selected");
    AST_ADV_DATA: assert property (($fell(flash_we_n) || $fell(ram_we_n))
        |-> address_valid_strobe_n) else $error("address strobe low in data phase");
    AST_FLASH_HOLD: assert property (s_flash_low |-> $stable(dq_host) && !dq_host_oe_n)
        else $error("flash write data moved before strobe rise");
    AST_RAM_HOLD: assert property (s_ram_low |-> $stable(dq_host))
        else $error("ram write data moved before strobe rise");
    AST_ONE_DIE: assert property ($onehot0({!flash_ce_n, !pram_die1_select_n,
        !pram_die2_select_n, !sram_select_low_n && sram_select_high}))
        else $error("more than one die selected");
    AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n[*8])
        else $error("flash write strobe too short");
endmodule

// ---- tb/testbench.sv ----
// self-checking bench: host end and memory end joined over the pin interface
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic req = 1'b0, req_write = 1'b0, req_cfg = 1'b0, wp_die1 = 1'b0, wp_others = 1'b0;
    logic [2:0]  req_die = 3'h0;
    logic [22:0] req_addr = 23'h000000;
    logic [15:0] req_data = 16'h0000;
    logic [1:0]  req_lanes = 2'h3;
    logic busy, done, write_seen, block_locked, pram_cfg_access;
    logic [15:0] rd_data, last_data, pram_refresh_ctrl_reg, pram_bus_ctrl_reg;
    logic [22:0] last_addr;
    logic [2:0]  last_die;
    int mismatches = 0, check_count = 0, cycles = 0, writes = 0;
    stack_bus_if bus_link();
    stack_host_end stack_host_end_inst (.ref_clk(ref_clk), .reset(reset), .bus(bus_link),
        .req(req), .req_write(req_write), .req_die(req_die), .req_addr(req_addr),
        .req_data(req_data), .req_lanes(req_lanes), .req_cfg(req_cfg), .wp_die1(wp_die1),
        .wp_others(wp_others), .busy(busy), .done(done), .rd_data(rd_data));
    stack_mem_end #(.pram_async_only(1'b0), .wait_active_high(1'b1), .read_latency(3'h2))
    stack_mem_end_inst (.ref_clk(ref_clk), .reset(reset), .bus(bus_link),
        .last_addr(last_addr), .last_data(last_data), .last_die(last_die),
        .write_seen(write_seen), .block_locked(block_locked), .pram_cfg_access(pram_cfg_access),
        .pram_refresh_ctrl_reg(pram_refresh_ctrl_reg), .pram_bus_ctrl_reg(pram_bus_ctrl_reg));
    stack_assertions #(.wait_active_high(1'b1)) stack_assertions_inst (.ref_clk(ref_clk),
        .reset(reset), .dq_host(bus_link.dq_host), .dq_host_oe_n(bus_link.dq_host_oe_n),
        .dq_mem_oe_n(bus_link.dq_mem_oe_n), .flash_ce_n(bus_link.flash_ce_n),
        .address_valid_strobe_n(bus_link.address_valid_strobe_n),
        .flash_oe_n(bus_link.flash_oe_n), .flash_we_n(bus_link.flash_we_n),
        .ram_we_n(bus_link.ram_we_n), .pram_die1_select_n(bus_link.pram_die1_select_n),
        .pram_die2_select_n(bus_link.pram_die2_select_n),
        .sram_select_low_n(bus_link.sram_select_low_n),
        .sram_select_high(bus_link.sram_select_high), .wait_out(bus_link.wait_out),
        .wait_oe_n(bus_link.wait_oe_n));
    always #20 ref_clk = ~ref_clk;
    // ==========================================================
    // write counter and hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (write_seen === 1'b1)
            writes++;
        if (cycles == 5000)
        begin
            mismatches++;
            summarize();
        end
    end
    // ==========================================================
    // reporting
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check_vec(input string name, input logic [22:0] exp, input logic [22:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one whole transfer; write_seen rises with done and writes counts it a cycle later, so settle afterwards
    task automatic xfer(input logic wr, input logic [2:0] die, input logic [22:0] addr,
                        input logic [15:0] data, input logic [1:0] lanes, input logic cfg);
        int n;
        n = 0;
        req_write = wr;
        req_die = die;
        req_addr = addr;
        req_data = data;
        req_lanes = lanes;
        req_cfg = cfg;
        req = 1'b1;
        @(posedge ref_clk);
        #1 req = 1'b0;
        while (done !== 1'b1 && n < 60)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        check_vec("done busy cfg", {20'h0, 2'h3, cfg && (die inside {3'h1, 3'h2})},
                  {20'h0, done, busy, pram_cfg_access});
        repeat (6) @(posedge ref_clk);
        #1 req_cfg = 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_flash_write;
        xfer(1'b1, 3'h0, 23'h1A5C3E, 16'hBEEF, 2'h3, 1'b0);
        check_vec("flash addr", 23'h1A5C3E, last_addr);
        check_vec("flash data", 23'h00BEEF, {7'h0, last_data});
        check_vec("flash die", 23'h0, {20'h0, last_die});
    endtask
    task automatic t_ram_writes;
        int base;
        base = writes;
        for (int d = 1; d <= 3; d++)
        begin
            xfer(1'b1, d[2:0], 23'h000100 + d[22:0], 16'hA5C3 + d[15:0], 2'h3, 1'b0);
            check_vec("ram die", {20'h0, d[2:0]}, {20'h0, last_die});
            check_vec("ram data", {7'h0, 16'hA5C3 + d[15:0]}, {7'h0, last_data});
        end
        check_vec("write count", base + 3, writes);
        xfer(1'b1, 3'h3, 23'h000200, 16'h5A3C, 2'h1, 1'b0);
        check_vec("lower lane", 23'h3C, {15'h0, last_data[7:0]});
        xfer(1'b1, 3'h1, 23'h000204, 16'h96E1, 2'h2, 1'b0);
        check_vec("upper lane", 23'h96, {15'h0, last_data[15:8]});
    endtask
    task automatic t_pram_regs;
        xfer(1'b1, 3'h1, 23'h000001, 16'h1234, 2'h3, 1'b1);
        check_vec("bus ctrl", 23'h1234, {7'h0, pram_bus_ctrl_reg});
        xfer(1'b1, 3'h2, 23'h000000, 16'h4321, 2'h3, 1'b1);
        check_vec("refresh ctrl", 23'h4321, {7'h0, pram_refresh_ctrl_reg});
    endtask
    task automatic t_lock;
        xfer(1'b1, 3'h0, 23'h000000, 16'h0001, 2'h3, 1'b0);
        check_vec("locked", 23'h1, {22'h0, block_locked});
        xfer(1'b1, 3'h0, 23'h000000, 16'h0000, 2'h3, 1'b0);
        check_vec("unlock refused", 23'h1, {22'h0, block_locked});
        wp_others = 1'b1;
        xfer(1'b1, 3'h0, 23'h000000, 16'h0000, 2'h3, 1'b0);
        check_vec("wrong pin", 23'h1, {22'h0, block_locked});
        xfer(1'b1, 3'h0, 23'h200000, 16'h0000, 2'h3, 1'b0);
        check_vec("others unlock", 23'h0, {22'h0, block_locked});
        xfer(1'b1, 3'h0, 23'h000000, 16'h0001, 2'h3, 1'b0);
        wp_die1 = 1'b1;
        xfer(1'b1, 3'h0, 23'h000000, 16'h0000, 2'h3, 1'b0);
        check_vec("die1 unlock", 23'h0, {22'h0, block_locked});
    endtask
    // reads exercise the wait drive and release checks
    task automatic t_reads;
        xfer(1'b0, 3'h0, 23'h000040, 16'h0000, 2'h3, 1'b0);
        check_vec("read data", 23'h4321, {7'h0, rd_data});
        xfer(1'b0, 3'h1, 23'h000044, 16'h0000, 2'h3, 1'b0);
        xfer(1'b0, 3'h3, 23'h000048, 16'h0000, 2'h3, 1'b0);
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        #1 reset = 1'b0;
        t_flash_write();
        t_ram_writes();
        t_pram_regs();
        t_reads();
        t_lock();
        summarize();
    end
endmodule
